// ---- rtl/pmvid_consts.vh ----
// Constants for the power-management voltage link manager
`ifndef PMVID_CONSTS_VH
`define PMVID_CONSTS_VH

// Register byte offsets
`define PMVID_CTRL_OFS 8'h00
`define PMVID_ADDR_LO_OFS 8'h04
`define PMVID_ADDR_HI_OFS 8'h08
`define PMVID_COEF_MB_OFS 8'h0c
`define PMVID_COEF_RN_OFS 8'h10
`define PMVID_VOUT_OFS 8'h14
`define PMVID_STATUS_OFS 8'h18
`define PMVID_IRQ_STAT_OFS 8'h1c
`define PMVID_IRQ_MASK_OFS 8'h20
`define PMVID_SLV_RX_OFS 8'h24
`define PMVID_CODE_OFS 8'h28

// Control field positions
`define PMVID_CTRL_EN 0
`define PMVID_CTRL_MASTER 1
`define PMVID_CTRL_FAST 2
`define PMVID_CTRL_FMT_LO 3
`define PMVID_CTRL_FMT_HI 4
`define PMVID_CTRL_VOLTS 5
`define PMVID_CTRL_PAGE_EN 6
`define PMVID_CTRL_PAGE_SEL 7
`define PMVID_CTRL_PAGE_LO 8
`define PMVID_CTRL_PAGE_HI 15
`define PMVID_CTRL_ALERT 16
`define PMVID_CTRL_OWN_LO 24
`define PMVID_CTRL_OWN_HI 30
`define PMVID_CTRL_RST 32'h0000_0000

// Output formats
`define PMVID_FMT_AUTO 2'h0
`define PMVID_FMT_DIRECT 2'h1
`define PMVID_FMT_LINEAR 2'h2

// Bus commands and page code
`define PMVID_CMD_PAGE 8'h00
`define PMVID_CMD_VOUT 8'h21
`define PMVID_PAGE_ALL 8'hff

// Interrupt bits
`define PMVID_IRQ_DONE 0
`define PMVID_IRQ_NACK 1
`define PMVID_IRQ_SLV_RX 2
`define PMVID_IRQ_CFG_ERR 3

// Timing
`define PMVID_CLK_HZ 50000000
`define PMVID_RATE_STD_HZ 100000
`define PMVID_RATE_FAST_HZ 400000

`endif

// ---- rtl/pmvid_manager.v ----
// Voltage link manager: AHB-Lite registers, bus master encoder and slave responder
// Behaviour
// - master bus clock runs at 100 kHz or 400 kHz, chosen by a control bit.
// - eight seven-bit regulator addresses held; first must be non-zero in master mode.
// - slave mode answers at its own configured seven-bit address.
// - addressing, rate, format and page settings matter only in master mode.
// - output code format is auto, direct or linear; auto is computed as direct, with no discovery.
// - direct and auto use signed sixteen-bit slope and offset coefficients.
// - direct and auto use a signed eight-bit decimal exponent.
// - linear format uses a five-bit two's complement exponent, -16 to 15.
// - requested voltage is read in millivolts or volts per a unit setting.
// - with paging on, a page command selecting all channels precedes the output command.
// - optionally the page command carries a chosen page value instead.
// - both modes use data and clock lines; alert is used only in slave mode.
// - alert line is active low, asserted by pulling low.
// - with the feature disabled, no bus or alert pin is driven.
// - user access is flagged only after the voltage setup completes.
//
// Design decisions made here: the register offsets and register access over AHB-Lite.
`include "pmvid_consts.vh"
`timescale 1ns/10ps
`default_nettype none

module pmvid_manager (
   input wire hclk,
   input wire hresetn,
   input wire hsel,
   input wire [31:0] haddr,
   input wire [1:0] htrans,
   input wire hwrite,
   input wire [2:0] hsize,
   input wire [31:0] hwdata,
   input wire hready,
   output reg [31:0] hrdata,
   output wire hreadyout,
   output wire hresp,
   input wire pm_bus_clock_pin_i,
   output wire pm_bus_clock_pin_o,
   output wire pm_bus_clock_pin_oe,
   input wire pm_bus_data_pin_i,
   output wire pm_bus_data_pin_o,
   output wire pm_bus_data_pin_oe,
   output wire pm_bus_alert_n_pin_o,
   output wire pm_bus_alert_n_pin_oe,
   output wire irq,
   output reg user_ready
);

   localparam integer STD_Q = (`PMVID_CLK_HZ + 4 * `PMVID_RATE_STD_HZ - 1)
      / (4 * `PMVID_RATE_STD_HZ);
   localparam integer FAST_Q = (`PMVID_CLK_HZ + 4 * `PMVID_RATE_FAST_HZ - 1)
      / (4 * `PMVID_RATE_FAST_HZ);

   localparam [2:0] M_IDLE = 3'h0;
   localparam [2:0] M_CALC = 3'h1;
   localparam [2:0] M_START = 3'h2;
   localparam [2:0] M_BIT = 3'h3;
   localparam [2:0] M_ACK = 3'h4;
   localparam [2:0] M_STOP = 3'h5;

   localparam [1:0] S_IDLE = 2'h0;
   localparam [1:0] S_RX = 2'h1;
   localparam [1:0] S_ACK = 2'h2;

   // Register file
   reg [31:0] ctrl_reg;
   reg [31:0] addr_lo_reg;
   reg [31:0] addr_hi_reg;
   reg [31:0] coef_mb_reg;
   reg [12:0] coef_rn_reg;
   reg [15:0] vout_reg;
   reg [3:0] irq_stat_reg;
   reg [3:0] irq_mask_reg;
   reg [15:0] slv_rx_reg;
   reg [15:0] code_reg;

   wire vid_en = ctrl_reg[`PMVID_CTRL_EN];
   wire master = ctrl_reg[`PMVID_CTRL_MASTER];
   wire [1:0] fmt = ctrl_reg[`PMVID_CTRL_FMT_HI:`PMVID_CTRL_FMT_LO];
   wire unit_volts = ctrl_reg[`PMVID_CTRL_VOLTS];
   wire page_en = ctrl_reg[`PMVID_CTRL_PAGE_EN];
   wire [7:0] page_val = ctrl_reg[`PMVID_CTRL_PAGE_SEL] ?
      ctrl_reg[`PMVID_CTRL_PAGE_HI:`PMVID_CTRL_PAGE_LO] : `PMVID_PAGE_ALL;
   wire [6:0] own_addr = ctrl_reg[`PMVID_CTRL_OWN_HI:`PMVID_CTRL_OWN_LO];
   wire [63:0] addr_all = {addr_hi_reg, addr_lo_reg};

   // Regulator addresses, one byte lane each, bit 7 unused
   wire [6:0] dev_addr [0:7];
   genvar gi;
   generate
      for (gi = 0; gi < 8; gi = gi + 1) begin : g_addr
         assign dev_addr[gi] = addr_all[gi * 8 +: 7];
      end
   endgenerate

   // AHB-Lite slave, zero wait states
   reg ph_wr_reg;
   reg [7:0] ph_addr_reg;
   wire take = hsel & htrans[1] & hready;
   wire rd_take = take & ~hwrite;
   wire wr_now = ph_wr_reg;
   wire go = wr_now && (ph_addr_reg == `PMVID_VOUT_OFS);
   wire irq_clr = rd_take && (haddr[7:0] == `PMVID_IRQ_STAT_OFS);
   wire hi_ok = (haddr[31:8] == 24'h00_0000);
   reg m_busy;

   assign hreadyout = 1'b1;
   assign hresp = 1'b0;

   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ph_wr_reg <= 1'b0;
         ph_addr_reg <= 8'h00;
      end else begin
         ph_wr_reg <= take & hwrite;
         ph_addr_reg <= haddr[7:0];
      end
   end

   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ctrl_reg <= `PMVID_CTRL_RST;
         addr_lo_reg <= 32'h0000_0000;
         addr_hi_reg <= 32'h0000_0000;
         coef_mb_reg <= 32'h0000_0000;
         coef_rn_reg <= 13'h0000;
         vout_reg <= 16'h0000;
         irq_mask_reg <= 4'h0;
      end else if (wr_now) begin
         case (ph_addr_reg)
            `PMVID_CTRL_OFS: ctrl_reg <= hwdata & 32'h7f01_ffff;
            `PMVID_ADDR_LO_OFS: addr_lo_reg <= hwdata & 32'h7f7f_7f7f;
            `PMVID_ADDR_HI_OFS: addr_hi_reg <= hwdata & 32'h7f7f_7f7f;
            `PMVID_COEF_MB_OFS: coef_mb_reg <= hwdata;
            `PMVID_COEF_RN_OFS: coef_rn_reg <= hwdata[12:0];
            `PMVID_VOUT_OFS: vout_reg <= hwdata[15:0];
            `PMVID_IRQ_MASK_OFS: irq_mask_reg <= hwdata[3:0];
            default: ;
         endcase
      end
   end

   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata <= 32'h0000_0000;
      end else if (rd_take) begin
         if (!hi_ok) begin
            hrdata <= 32'h0000_0000;
         end else begin
            case (haddr[7:0])
               `PMVID_CTRL_OFS: hrdata <= ctrl_reg;
               `PMVID_ADDR_LO_OFS: hrdata <= addr_lo_reg;
               `PMVID_ADDR_HI_OFS: hrdata <= addr_hi_reg;
               `PMVID_COEF_MB_OFS: hrdata <= coef_mb_reg;
               `PMVID_COEF_RN_OFS: hrdata <= {19'h0_0000, coef_rn_reg};
               `PMVID_VOUT_OFS: hrdata <= {16'h0000, vout_reg};
               `PMVID_STATUS_OFS: hrdata <= {29'h0000_0000,
                  pm_bus_alert_n_pin_oe, user_ready, m_busy};
               `PMVID_IRQ_STAT_OFS: hrdata <= {28'h000_0000, irq_stat_reg};
               `PMVID_IRQ_MASK_OFS: hrdata <= {28'h000_0000, irq_mask_reg};
               `PMVID_SLV_RX_OFS: hrdata <= {16'h0000, slv_rx_reg};
               `PMVID_CODE_OFS: hrdata <= {16'h0000, code_reg};
               default: hrdata <= 32'h0000_0000;
            endcase
         end
      end
   end

   // Pin synchronisers; only the second stage and its delayed copy feed logic
   reg [1:0] scl_sync_reg;
   reg [1:0] sda_sync_reg;
   reg scl_d_reg;
   reg sda_d_reg;
   wire scl_s = scl_sync_reg[1];
   wire sda_s = sda_sync_reg[1];

   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         scl_sync_reg <= 2'h3;
         sda_sync_reg <= 2'h3;
         scl_d_reg <= 1'b1;
         sda_d_reg <= 1'b1;
      end else begin
         scl_sync_reg <= {scl_sync_reg[0], pm_bus_clock_pin_i};
         sda_sync_reg <= {sda_sync_reg[0], pm_bus_data_pin_i};
         scl_d_reg <= scl_s;
         sda_d_reg <= sda_s;
      end
   end

   // Quarter-bit enable for the master clock
   reg [7:0] div_reg;
   wire [7:0] div_top = ctrl_reg[`PMVID_CTRL_FAST] ? FAST_Q[7:0] - 8'h01
      : STD_Q[7:0] - 8'h01;
   wire qtick = (div_reg == 8'h00);

   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         div_reg <= 8'h00;
      end else if (qtick || div_reg > div_top) begin
         div_reg <= div_top;
      end else begin
         div_reg <= div_reg - 8'h01;
      end
   end

   // Byte to send in a master transaction
   function [7:0] mbyte;
      input [6:0] adr;
      input txn;
      input [1:0] idx;
      input [7:0] page;
      input [15:0] code;
      begin
         case ({txn, idx})
            3'h0: mbyte = {adr, 1'b0};
            3'h1: mbyte = `PMVID_CMD_PAGE;
            3'h2: mbyte = page;
            3'h4: mbyte = {adr, 1'b0};
            3'h5: mbyte = `PMVID_CMD_VOUT;
            3'h6: mbyte = code[7:0];
            3'h7: mbyte = code[15:8];
            default: mbyte = 8'hff;
         endcase
      end
   endfunction

   reg [2:0] m_st;
   reg [1:0] q_reg;
   reg scl_lvl_reg;
   reg sda_lvl_reg;
   reg [7:0] sh_reg;
   reg [2:0] bit_reg;
   reg [2:0] dev_reg;
   reg txn_reg;
   reg [1:0] bidx_reg;
   reg abort_reg;
   reg ack_bad_reg;
   reg signed [47:0] acc_reg;
   reg signed [8:0] exp_reg;
   reg ev_done;
   reg ev_nack;
   reg ev_cfg;
   reg ev_srx;

   wire signed [15:0] coef_m = coef_mb_reg[15:0];
   wire signed [15:0] coef_b = coef_mb_reg[31:16];
   wire signed [7:0] coef_r = coef_rn_reg[7:0];
   wire signed [4:0] lin_n = coef_rn_reg[12:8];
   // Start write lands this edge
   wire [15:0] vin = go ? hwdata[15:0] : vout_reg;
   wire signed [16:0] vx = {1'b0, vin};
   wire signed [33:0] dir_val = coef_m * vx + coef_b;
   wire [4:0] lin_neg = 5'h00 - lin_n;
   wire signed [47:0] lin_val = lin_n[4] ? ({32'h0000_0000, vin} << lin_neg)
      : ({32'h0000_0000, vin} >> lin_n);
   // Millivolt requests carry an extra decade of three toward volts
   wire signed [8:0] unit_adj = unit_volts ? 9'sd0 : -9'sd3;
   wire last_byte = (bidx_reg == (txn_reg ? 2'h3 : 2'h2));
   wire next_ok = (dev_reg != 3'h7) && (dev_addr[dev_reg + 3'h1] != 7'h00);
   wire [7:0] cur_byte = mbyte(dev_addr[dev_reg], txn_reg, bidx_reg, page_val,
      code_reg);

   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         m_st <= M_IDLE;
         q_reg <= 2'h0;
         scl_lvl_reg <= 1'b1;
         sda_lvl_reg <= 1'b1;
         sh_reg <= 8'h00;
         bit_reg <= 3'h0;
         dev_reg <= 3'h0;
         txn_reg <= 1'b0;
         bidx_reg <= 2'h0;
         abort_reg <= 1'b0;
         ack_bad_reg <= 1'b0;
         acc_reg <= 48'sh0;
         exp_reg <= 9'sh0;
         code_reg <= 16'h0000;
         m_busy <= 1'b0;
         ev_done <= 1'b0;
         ev_nack <= 1'b0;
         ev_cfg <= 1'b0;
      end else begin
         ev_done <= 1'b0;
         ev_nack <= 1'b0;
         ev_cfg <= 1'b0;
         if (qtick && m_st != M_IDLE && m_st != M_CALC) begin
            q_reg <= q_reg + 2'h1;
         end
         case (m_st)
            M_IDLE: begin
               m_busy <= 1'b0;
               q_reg <= 2'h0;
               if (go && vid_en && master) begin
                  if (dev_addr[0] == 7'h00) begin
                     ev_cfg <= 1'b1;
                  end else begin
                     m_busy <= 1'b1;
                     m_st <= M_CALC;
                     if (fmt == `PMVID_FMT_LINEAR) begin
                        acc_reg <= lin_val;
                        exp_reg <= unit_adj;
                     end else begin
                        acc_reg <= {{14{dir_val[33]}}, dir_val};
                        exp_reg <= {coef_r[7], coef_r} + unit_adj;
                     end
                  end
               end
            end
            M_CALC: begin
               if (exp_reg > 9'sd0) begin
                  acc_reg <= acc_reg * 10;
                  exp_reg <= exp_reg - 9'sd1;
               end else if (exp_reg < 9'sd0) begin
                  acc_reg <= acc_reg / 10;
                  exp_reg <= exp_reg + 9'sd1;
               end else begin
                  code_reg <= acc_reg[15:0];
                  dev_reg <= 3'h0;
                  txn_reg <= ~page_en;
                  bidx_reg <= 2'h0;
                  abort_reg <= 1'b0;
                  m_st <= M_START;
               end
            end
            M_START: if (qtick) begin
               case (q_reg)
                  2'h0: begin
                     sda_lvl_reg <= 1'b1;
                     scl_lvl_reg <= 1'b1;
                  end
                  2'h1: sda_lvl_reg <= 1'b0;
                  2'h2: scl_lvl_reg <= 1'b0;
                  default: begin
                     sh_reg <= cur_byte;
                     bit_reg <= 3'h0;
                     m_st <= M_BIT;
                  end
               endcase
            end
            M_BIT: if (qtick) begin
               case (q_reg)
                  2'h0: sda_lvl_reg <= sh_reg[7];
                  2'h1: scl_lvl_reg <= 1'b1;
                  2'h2: ;
                  default: begin
                     scl_lvl_reg <= 1'b0;
                     sh_reg <= {sh_reg[6:0], 1'b0};
                     bit_reg <= bit_reg + 3'h1;
                     if (bit_reg == 3'h7) begin
                        m_st <= M_ACK;
                     end
                  end
               endcase
            end
            M_ACK: if (qtick) begin
               case (q_reg)
                  2'h0: sda_lvl_reg <= 1'b1;
                  2'h1: scl_lvl_reg <= 1'b1;
                  2'h2: ack_bad_reg <= sda_s;
                  default: begin
                     scl_lvl_reg <= 1'b0;
                     if (ack_bad_reg) begin
                        abort_reg <= 1'b1;
                        m_st <= M_STOP;
                     end else if (last_byte) begin
                        m_st <= M_STOP;
                     end else begin
                        bidx_reg <= bidx_reg + 2'h1;
                        sh_reg <= mbyte(dev_addr[dev_reg], txn_reg, bidx_reg + 2'h1,
                           page_val, code_reg);
                        bit_reg <= 3'h0;
                        m_st <= M_BIT;
                     end
                  end
               endcase
            end
            M_STOP: if (qtick) begin
               case (q_reg)
                  2'h0: sda_lvl_reg <= 1'b0;
                  2'h1: scl_lvl_reg <= 1'b1;
                  2'h2: sda_lvl_reg <= 1'b1;
                  default: begin
                     bidx_reg <= 2'h0;
                     if (abort_reg) begin
                        ev_nack <= 1'b1;
                        m_st <= M_IDLE;
                     end else if (!txn_reg) begin
                        txn_reg <= 1'b1;
                        m_st <= M_START;
                     end else if (next_ok) begin
                        dev_reg <= dev_reg + 3'h1;
                        txn_reg <= ~page_en;
                        m_st <= M_START;
                     end else begin
                        ev_done <= 1'b1;
                        m_st <= M_IDLE;
                     end
                  end
               endcase
            end
            default: m_st <= M_IDLE;
         endcase
      end
   end

   // Slave responder: write transfers to the own address only
   reg [1:0] s_st;
   reg [3:0] s_cnt;
   reg [7:0] s_sh;
   reg s_first;
   reg s_cmd_phase;
   reg s_drv;
   wire s_on = vid_en & ~master;
   wire scl_rise = scl_s & ~scl_d_reg;
   wire scl_fall = ~scl_s & scl_d_reg;
   wire bus_start = scl_s & scl_d_reg & sda_d_reg & ~sda_s;
   wire bus_stop = scl_s & scl_d_reg & ~sda_d_reg & sda_s;

   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         s_st <= S_IDLE;
         s_cnt <= 4'h0;
         s_sh <= 8'h00;
         s_first <= 1'b0;
         s_cmd_phase <= 1'b0;
         s_drv <= 1'b0;
         slv_rx_reg <= 16'h0000;
         ev_srx <= 1'b0;
      end else begin
         ev_srx <= 1'b0;
         if (!s_on || bus_stop) begin
            s_st <= S_IDLE;
            s_drv <= 1'b0;
         end else if (bus_start) begin
            s_st <= S_RX;
            s_cnt <= 4'h0;
            s_first <= 1'b1;
            s_cmd_phase <= 1'b1;
            s_drv <= 1'b0;
         end else begin
            case (s_st)
               S_IDLE: s_drv <= 1'b0;
               S_RX: begin
                  if (scl_rise && s_cnt != 4'h8) begin
                     s_sh <= {s_sh[6:0], sda_s};
                     s_cnt <= s_cnt + 4'h1;
                  end else if (scl_fall && s_cnt == 4'h8) begin
                     if (s_first) begin
                        if (s_sh == {own_addr, 1'b0}) begin
                           s_drv <= 1'b1;
                           s_st <= S_ACK;
                        end else begin
                           s_st <= S_IDLE;
                        end
                     end else begin
                        s_drv <= 1'b1;
                        s_st <= S_ACK;
                        ev_srx <= 1'b1;
                        if (s_cmd_phase) begin
                           slv_rx_reg[7:0] <= s_sh;
                        end else begin
                           slv_rx_reg[15:8] <= s_sh;
                        end
                     end
                  end
               end
               S_ACK: if (scl_fall) begin
                  s_drv <= 1'b0;
                  s_cnt <= 4'h0;
                  s_cmd_phase <= s_first;
                  s_first <= 1'b0;
                  s_st <= S_RX;
               end
               default: s_st <= S_IDLE;
            endcase
         end
      end
   end

   // Interrupts: set wins over the read clear
   wire [3:0] irq_ev;
   assign irq_ev[`PMVID_IRQ_DONE] = ev_done;
   assign irq_ev[`PMVID_IRQ_NACK] = ev_nack;
   assign irq_ev[`PMVID_IRQ_SLV_RX] = ev_srx;
   assign irq_ev[`PMVID_IRQ_CFG_ERR] = ev_cfg;
   assign irq = |(irq_stat_reg & irq_mask_reg);

   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         irq_stat_reg <= 4'h0;
         user_ready <= 1'b0;
      end else begin
         irq_stat_reg <= (irq_clr ? 4'h0 : irq_stat_reg) | irq_ev;
         // Core access waits for a completed setup; disabling withdraws it
         if (!vid_en) begin
            user_ready <= 1'b0;
         end else if (ev_done || (ev_srx && s_cmd_phase == 1'b0
            && slv_rx_reg[7:0] == `PMVID_CMD_VOUT)) begin
            user_ready <= 1'b1;
         end
      end
   end

   // Open-drain pins: only ever pulled low, nothing driven while disabled
   assign pm_bus_clock_pin_o = 1'b0;
   assign pm_bus_data_pin_o = 1'b0;
   assign pm_bus_alert_n_pin_o = 1'b0;
   assign pm_bus_clock_pin_oe = vid_en & master & ~scl_lvl_reg;
   assign pm_bus_data_pin_oe = vid_en & (master ? ~sda_lvl_reg : s_drv);
   assign pm_bus_alert_n_pin_oe = s_on & ctrl_reg[`PMVID_CTRL_ALERT];

endmodule // pmvid_manager

`default_nettype wire

// ---- test/pmvid_properties.sv ----
// Checker for the pin and status behaviour of the voltage link manager
`timescale 1ns/10ps
`default_nettype none
module pmvid_properties (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   input wire logic irq,
   input wire logic user_ready,
   input wire logic pm_bus_clock_pin_o,
   input wire logic pm_bus_clock_pin_oe,
   input wire logic pm_bus_data_pin_o,
   input wire logic pm_bus_data_pin_oe,
   input wire logic pm_bus_alert_n_pin_o,
   input wire logic pm_bus_alert_n_pin_oe
);
   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);
   logic wr_ph;
   logic [31:0] ctrl_sh;
   logic [9:0] hi_cnt;
   // Shadow of the control word, so mode checks need no internal probes
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_ph <= 1'b0;
         ctrl_sh <= 32'h0;
         hi_cnt <= 10'h3ff;
      end else begin
         if (wr_ph) ctrl_sh <= hwdata & 32'h7f01ffff;
         wr_ph <= hsel && htrans[1] && hready && hwrite && haddr == 32'h0;
         hi_cnt <= pm_bus_clock_pin_oe ? 10'h0 : (hi_cnt == 10'h3ff ? hi_cnt : hi_cnt + 10'h1);
      end
   end
   sequence s_quiet;
      !pm_bus_clock_pin_oe && !pm_bus_data_pin_oe && !pm_bus_alert_n_pin_oe;
   endsequence
   a_open_drain: assert property (!pm_bus_clock_pin_o && !pm_bus_data_pin_o)
      else $error("bus line driven high");
   a_alert_low_level: assert property (!pm_bus_alert_n_pin_o)
      else $error("alert driven high");
   a_rate_ceiling: assert property ($rose(pm_bus_clock_pin_oe) |-> hi_cnt >= 10'd63)
      else $error("clock high phase too short");
   a_off_quiet: assert property (!ctrl_sh[0] ##1 !ctrl_sh[0] |-> s_quiet)
      else $error("pin driven while disabled");
   a_alert_slave_only: assert property (pm_bus_alert_n_pin_oe |->
      ctrl_sh[0] && !ctrl_sh[1])
      else $error("alert outside slave mode");
   a_alert_on: assert property (ctrl_sh[0] && !ctrl_sh[1] && ctrl_sh[16]
      |-> pm_bus_alert_n_pin_oe)
      else $error("alert not asserted");
   a_slave_no_clock: assert property (ctrl_sh[0] && !ctrl_sh[1] |=> !pm_bus_clock_pin_oe)
      else $error("clock driven in slave mode");
   a_ready_cleared: assert property (!ctrl_sh[0] |=> !user_ready)
      else $error("user ready while disabled");
   a_reset_quiet: assert property ($rose(hresetn) |-> s_quiet ##0 (!irq && !user_ready))
      else $error("outputs active after reset");
endmodule // pmvid_properties
bind pmvid_manager pmvid_properties chk_u (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
   .hwdata, .hready, .irq, .user_ready, .pm_bus_clock_pin_o, .pm_bus_clock_pin_oe,
   .pm_bus_data_pin_o, .pm_bus_data_pin_oe, .pm_bus_alert_n_pin_o, .pm_bus_alert_n_pin_oe);
`default_nettype wire

// ---- test/pmvid_reg_model.sv ----
// Regulator model: acknowledges every byte and records what it received
`timescale 1ns/10ps
`default_nettype none
module pmvid_reg_model (
   input wire logic scl,
   input wire logic sda,
   output logic sda_oe
);
   logic [7:0] sh;
   int n;
   logic [7:0] got[$];
   initial begin
      sda_oe = 1'b0;
      n = 0;
   end
   always @(negedge sda) if (scl === 1'b1) n = 0;
   always @(posedge scl) begin
      if (n < 8) sh = {sh[6:0], sda};
      n++;
      if (n == 8) got.push_back(sh);
      if (n == 9) n = 0;
   end
   // Pull low only for the acknowledge bit, released on clock fall
   always @(negedge scl) sda_oe = (n == 8);
endmodule // pmvid_reg_model
`default_nettype wire

// ---- test/pmvid_manager_tb_top.sv ----
// Self-checking bench for the voltage link manager
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin mismatches++; \
   $display("MISMATCH %0t got %h exp %h", $time, a, e); end end
module pmvid_manager_tb_top;
   logic hclk, hresetn, hsel, hwrite;
   logic ctl_scl = 1'b1, ctl_sda = 1'b1;
   logic [31:0] haddr, hwdata, q;
   logic [1:0] htrans;
   logic [2:0] hsize;
   wire logic [31:0] hrdata;
   wire logic hreadyout, hresp, irq, user_ready, reg_oe;
   wire logic pm_bus_clock_pin_o, pm_bus_clock_pin_oe, pm_bus_data_pin_o, pm_bus_data_pin_oe;
   wire logic pm_bus_alert_n_pin_o, pm_bus_alert_n_pin_oe;
   // Pulled-up open-drain lines
   wire logic scl = !pm_bus_clock_pin_oe && ctl_scl;
   wire logic sda = !(pm_bus_data_pin_oe | reg_oe) && ctl_sda;
   int mismatches, n_checks, cyc, i;
   time t_last, per;
   pmvid_manager dut_u (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
      .hready(hreadyout), .hrdata, .hreadyout, .hresp, .pm_bus_clock_pin_i(scl),
      .pm_bus_clock_pin_o, .pm_bus_clock_pin_oe, .pm_bus_data_pin_i(sda), .pm_bus_data_pin_o,
      .pm_bus_data_pin_oe, .pm_bus_alert_n_pin_o, .pm_bus_alert_n_pin_oe, .irq, .user_ready);
   pmvid_reg_model m_u (.scl, .sda, .sda_oe(reg_oe));
   initial begin
      hclk = 1'b0;
      forever #10 hclk = ~hclk;
   end
   always @(posedge scl) begin
      per = $time - t_last;
      t_last = $time;
   end
   task tally_and_finish;
      $display("checks %0d mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   always @(posedge hclk) begin
      cyc++;
      if (cyc == 60000) begin
         mismatches++;
         tally_and_finish;
      end
   end
   task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge hclk);
      hsel <= 1'b1;
      htrans <= 2'h2;
      hwrite <= w;
      haddr <= {24'h0, a};
      do @(posedge hclk); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      q = hrdata;
   endtask
   task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
      ahb(1'b0, a, 32'h0);
      `CHK(q, e)
   endtask
   task automatic frame(input int n, input logic [55:0] e);
      `CHK(m_u.got.size(), n)
      for (i = 0; i < n; i++) `CHK(m_u.got[i], e[8*(n-1-i) +: 8])
      m_u.got.delete();
   endtask
   task automatic wait_idle;
      for (i = 0; i < 20000; i++) begin
         ahb(1'b0, 8'h18, 32'h0);
         if (q[0] === 1'b0) break;
      end
   endtask
   task automatic ctl_cond(input logic s);
      ctl_sda <= 1'b0;
      repeat (4) @(posedge hclk);
      ctl_scl <= !s;
      repeat (4) @(posedge hclk);
      ctl_sda <= !s;
      repeat (4) @(posedge hclk);
   endtask
   task automatic ctl_byte(input logic [7:0] b);
      for (i = 8; i >= 0; i--) begin
         ctl_sda <= (i == 0) ? 1'b1 : b[i-1];
         repeat (2) @(posedge hclk);
         ctl_scl <= 1'b1;
         repeat (4) @(posedge hclk);
         if (i == 0) `CHK(pm_bus_data_pin_oe, 1'b1)
         ctl_scl <= 1'b0;
         repeat (2) @(posedge hclk);
      end
   endtask
   initial begin
      hresetn = 1'b0;
      hsel = 1'b0;
      htrans = 2'h0;
      hwrite = 1'b0;
      haddr = 32'h0;
      hwdata = 32'h0;
      hsize = 3'h2;
      repeat (8) @(posedge hclk);
      hresetn <= 1'b1;
      rd_chk(8'h00, 32'h0);
      rd_chk(8'h40, 32'h0);
      `CHK({pm_bus_clock_pin_oe, pm_bus_data_pin_oe, pm_bus_alert_n_pin_oe, hresp}, 4'h0)
      $display("test reset_values done");
      ahb(1'b1, 8'h20, 32'hf);
      ahb(1'b1, 8'h00, 32'h3);
      ahb(1'b1, 8'h14, 32'h1);
      repeat (2) @(negedge hclk);
      `CHK(irq, 1'b1)
      rd_chk(8'h1c, 32'h8);
      @(negedge hclk);
      `CHK(irq, 1'b0)
      frame(0, 56'h0);
      $display("test zero_address done");
      ahb(1'b1, 8'h0c, 32'h00050002);
      ahb(1'b1, 8'h10, 32'h1);
      ahb(1'b1, 8'h04, 32'h41);
      ahb(1'b1, 8'h00, 32'h6f);
      ahb(1'b1, 8'h20, 32'h1);
      ahb(1'b1, 8'h14, 32'h64);
      wait_idle;
      frame(7, 56'h8200ff82210208);
      rd_chk(8'h28, 32'h0802);
      `CHK(per, 2560)
      `CHK({irq, user_ready}, 2'h3)
      rd_chk(8'h1c, 32'h1);
      $display("test direct_fast done");
      ahb(1'b1, 8'h10, 32'h1e00);
      ahb(1'b1, 8'h20, 32'h0);
      ahb(1'b1, 8'h00, 32'h3d3);
      ahb(1'b1, 8'h14, 32'h1388);
      wait_idle;
      frame(7, 56'h82000382211400);
      `CHK(per, 10000)
      `CHK(irq, 1'b0)
      rd_chk(8'h1c, 32'h1);
      $display("test linear_slow done");
      ahb(1'b1, 8'h00, 32'h2a010001);
      @(negedge hclk);
      `CHK({pm_bus_alert_n_pin_oe, pm_bus_alert_n_pin_o, pm_bus_clock_pin_oe}, 3'h4)
      ahb(1'b1, 8'h00, 32'h00010003);
      @(negedge hclk);
      `CHK(pm_bus_alert_n_pin_oe, 1'b0)
      ahb(1'b1, 8'h00, 32'h00010000);
      repeat (2) @(negedge hclk);
      `CHK({scl, pm_bus_data_pin_oe, pm_bus_alert_n_pin_oe, user_ready}, 4'h8)
      $display("test alert_modes done");
      ahb(1'b1, 8'h00, 32'h2a000001);
      ahb(1'b1, 8'h20, 32'h4);
      ctl_cond(1'b1);
      ctl_byte(8'h54);
      ctl_byte(8'h21);
      ctl_byte(8'h5a);
      ctl_cond(1'b0);
      `CHK({irq, user_ready}, 2'h3)
      rd_chk(8'h24, 32'h5a21);
      $display("test slave_rx done");
      tally_and_finish;
   end
endmodule // pmvid_manager_tb_top
`default_nettype wire
